// *** bct_core.sv ***
// Execution core for conditional branches and the bit-test instruction.
// Assumes a memory whose read data follows mem_addr in the same cycle,
// an Avalon-MM master on the register port, and a synchronous pin input.
//
// Behaviour
// - Pin-high branch taken when pin high, three cycles
// - Pin-low branch taken when pin low, three cycles
// - Target is opcode address plus two plus offset
// - Bit test ANDs, writes back nothing
// - Immediate, direct, extended bit test cycle counts
// - Indexed bit test forms and cycle counts
// - Stack-relative bit test uses prefix byte
// - Signed less-or-equal: Z or N xor V
// - Unsigned lower: carry set
// - Unsigned lower-or-same: carry or zero
// - Signed less-than: N xor V
// - Unmasked branch: interrupt mask clear
`timescale 1ns/1ps
module bct_core
  import bct_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register bus
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Program and data memory
  output logic [15:0] mem_addr,
  output logic mem_rd,
  input wire logic [7:0] mem_rdata,
  // External interrupt pin level and retire pulse
  input wire logic ext_int_pin,
  output logic instr_done
);

  bct_state_t state;
  logic [2:0] cyc;
  logic [2:0] stage;
  logic prefixed;
  logic [7:0] op;
  logic [7:0] hi;
  logic [7:0] rel;
  logic [15:0] pc;
  logic [7:0] acc;
  logic [15:0] hx;
  logic [15:0] sp;
  logic [7:0] flags;
  logic [2:0] last_cyc;
  logic run;
  logic step;
  logic badop;
  logic first_byte;
  logic retire;
  logic bad_first;
  logic [15:0] base;
  logic [15:0] br_target;
  logic [15:0] pc_plus2;
  logic [7:0] and_res;
  logic bus_wr;
  bct_eval_if ev ();

  bct_eval u_eval (
    .e(ev)
  );

  // ==========================================================
  // Decode of the current cycle
  assign stage = cyc - {2'h0, prefixed};
  assign first_byte = (state == BCT_EXEC) &&
                      ((cyc == 3'h0 && mem_rdata != OP_PREFIX_SP) || (cyc == 3'h1 && prefixed));
  assign bad_first = first_byte && bct_op_cycles(mem_rdata, prefixed) == 3'h0;
  assign retire = (state == BCT_EXEC) && !first_byte && cyc != 3'h0 &&
                  cyc == bct_op_cycles(op, prefixed) - 3'h1;
  assign base = prefixed ? sp : hx;
  assign pc_plus2 = pc + BRANCH_BASE;
  assign br_target = pc_plus2 + {{8{rel[7]}}, rel};
  assign and_res = acc & mem_rdata;
  assign bus_wr = avs_write && !avs_waitrequest;

  // Evaluator inputs
  assign ev.opcode = op;
  assign ev.prefixed = prefixed;
  assign ev.flags = flags;
  assign ev.acc = acc;
  assign ev.operand = mem_rdata;
  assign ev.pin = ext_int_pin;

  // ==========================================================
  // Sequencer: one memory byte per cycle except a branch's last cycle, retire on the last cycle
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state <= BCT_IDLE;
      cyc <= 3'h0;
      prefixed <= 1'b0;
      op <= 8'h00;
      hi <= 8'h00;
      rel <= 8'h00;
      mem_addr <= 16'h0000;
      mem_rd <= 1'b0;
      instr_done <= 1'b0;
      last_cyc <= 3'h0;
    end
    else
    begin
      instr_done <= 1'b0;
      case (state)
        BCT_IDLE, BCT_DONE:
        begin
          if ((step || run) && !badop)
          begin
            state <= BCT_EXEC;
            cyc <= 3'h0;
            prefixed <= 1'b0;
            mem_addr <= pc;
            mem_rd <= 1'b1;
          end
          else
            state <= BCT_IDLE;
        end
        BCT_EXEC:
        begin
          cyc <= cyc + 3'h1;
          if (bad_first || retire)
          begin
            state <= BCT_DONE;
            mem_rd <= 1'b0;
            instr_done <= 1'b1;
            last_cyc <= cyc + 3'h1;
          end
          else if (cyc == 3'h0 && mem_rdata == OP_PREFIX_SP)
          begin
            prefixed <= 1'b1;
            mem_addr <= pc + 16'h0001;
          end
          else if (first_byte)
          begin
            op <= mem_rdata;
            if (!prefixed && mem_rdata == OP_BIT_IX)
              mem_addr <= hx;
            else
              mem_addr <= pc + {13'h0000, cyc} + 16'h0001;
          end
          else if (ev.is_branch)
          begin
            rel <= mem_rdata;
            mem_rd <= 1'b0;
          end
          else if (op == OP_BIT_DIR)
            mem_addr <= {8'h00, mem_rdata};
          else if (op == OP_BIT_IX1)
            mem_addr <= base + {8'h00, mem_rdata};
          else if (stage == 3'h1)
          begin
            hi <= mem_rdata;
            mem_addr <= pc + {13'h0000, cyc} + 16'h0001;
          end
          else if (op == OP_BIT_EXT)
            mem_addr <= {hi, mem_rdata};
          else
            mem_addr <= base + {hi, mem_rdata};
        end
        default:
          state <= BCT_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Architectural registers: engine updates, bus writes while idle
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      pc <= PC_RST;
      acc <= 8'h00;
      hx <= 16'h0000;
      sp <= SP_RST;
      flags <= FLAGS_RST;
    end
    else if (retire)
    begin
      if (ev.is_branch)
        pc <= ev.taken ? br_target : pc_plus2;
      else
      begin
        pc <= pc + bct_op_len(op, prefixed);
        flags <= ev.flags_bit | FLAGS_FIXED;
      end
    end
    else if (bus_wr && state == BCT_IDLE)
    begin
      if (avs_address == REG_PC)
      begin
        if (avs_byteenable[0]) pc[7:0] <= avs_writedata[7:0];
        if (avs_byteenable[1]) pc[15:8] <= avs_writedata[15:8];
      end
      else if (avs_address == REG_ACC && avs_byteenable[0])
        acc <= avs_writedata[7:0];
      else if (avs_address == REG_INDEX)
      begin
        if (avs_byteenable[0]) hx[7:0] <= avs_writedata[7:0];
        if (avs_byteenable[1]) hx[15:8] <= avs_writedata[15:8];
      end
      else if (avs_address == REG_SP)
      begin
        if (avs_byteenable[0]) sp[7:0] <= avs_writedata[7:0];
        if (avs_byteenable[1]) sp[15:8] <= avs_writedata[15:8];
      end
      else if (avs_address == REG_FLAGS && avs_byteenable[0])
        flags <= avs_writedata[7:0] | FLAGS_FIXED;
    end
  end

  // ==========================================================
  // Control and sticky fault; the fault set wins over a clear
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      run <= 1'b0;
      step <= 1'b0;
      badop <= 1'b0;
    end
    else
    begin
      step <= 1'b0;
      if (bus_wr && avs_address == REG_CTRL && avs_byteenable[0])
      begin
        step <= avs_writedata[CTRL_STEP];
        run <= avs_writedata[CTRL_RUN];
      end
      if (bus_wr && avs_address == REG_STATUS && avs_byteenable[0] &&
          avs_writedata[ST_BADOP])
        badop <= 1'b0;
      if (bad_first)
      begin
        badop <= 1'b1;
        run <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Bus slave: one wait cycle, then accept with data
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end
    else if ((avs_read || avs_write) && avs_waitrequest)
    begin
      avs_waitrequest <= 1'b0;
      if (avs_address == REG_CTRL)
        avs_readdata <= {30'h0000_0000, run, 1'b0};
      else if (avs_address == REG_STATUS)
        avs_readdata <= {30'h0000_0000, badop, state != BCT_IDLE};
      else if (avs_address == REG_PC)
        avs_readdata <= {16'h0000, pc};
      else if (avs_address == REG_ACC)
        avs_readdata <= {24'h00_0000, acc};
      else if (avs_address == REG_INDEX)
        avs_readdata <= {16'h0000, hx};
      else if (avs_address == REG_SP)
        avs_readdata <= {16'h0000, sp};
      else if (avs_address == REG_FLAGS)
        avs_readdata <= {24'h00_0000, flags};
      else if (avs_address == REG_LAST_CYC)
        avs_readdata <= {29'h0000_0000, last_cyc};
      else
        avs_readdata <= 32'h0000_0000;
    end
    else
      avs_waitrequest <= 1'b1;
  end

  // ==========================================================
  // Checks
  property p_pin_hi;
    @(posedge mclk) disable iff (rst)
    (retire && !prefixed && op == OP_BR_PIN_HI) |-> cyc == 3'h2 ##1
      pc == ($past(ext_int_pin) ? $past(br_target) : $past(pc_plus2));
  endproperty
  a_pin_hi: assert property (p_pin_hi) else $error("pin-high branch wrong");
  property p_pin_lo;
    @(posedge mclk) disable iff (rst)
    (retire && !prefixed && op == OP_BR_PIN_LO) |-> cyc == 3'h2 ##1
      pc == ($past(ext_int_pin) ? $past(pc_plus2) : $past(br_target));
  endproperty
  a_pin_lo: assert property (p_pin_lo) else $error("pin-low branch wrong");
  property p_target;
    @(posedge mclk) disable iff (rst)
    (retire && ev.is_branch && ev.taken) |=> pc == $past(br_target) && flags == $past(flags);
  endproperty
  a_target: assert property (p_target) else $error("branch target wrong");
  property p_no_write;
    @(posedge mclk) disable iff (rst)
    (retire && !ev.is_branch) |=> acc == $past(acc) && !mem_rd;
  endproperty
  a_no_write: assert property (p_no_write) else $error("bit test altered data");
  property p_bit_flags;
    @(posedge mclk) disable iff (rst)
    (retire && !ev.is_branch) |=> !flags[FLG_V] && flags[FLG_N] == $past(and_res[7])
      && flags[FLG_Z] == ($past(and_res) == 8'h00) && flags[FLG_H] == $past(flags[FLG_H])
      && flags[FLG_C] == $past(flags[FLG_C]) && flags[FLG_I] == $past(flags[FLG_I]);
  endproperty
  a_bit_flags: assert property (p_bit_flags) else $error("bit test flags wrong");
  property p_ext_cyc;
    @(posedge mclk) disable iff (rst)
    (retire && !prefixed && op == OP_BIT_EXT) |-> cyc == 3'h3 && mem_addr == {$past(hi), $past(mem_rdata)};
  endproperty
  a_ext_cyc: assert property (p_ext_cyc) else $error("extended bit test timing");
  property p_ix2_cyc;
    @(posedge mclk) disable iff (rst)
    (retire && !prefixed && op == OP_BIT_IX2) |-> cyc == 3'h3;
  endproperty
  a_ix2_cyc: assert property (p_ix2_cyc) else $error("indexed bit test timing");
  property p_sp2_cyc;
    @(posedge mclk) disable iff (rst)
    (retire && prefixed && op == OP_BIT_IX2) |-> cyc == 3'h4 && $past(mem_addr, 4) == pc;
  endproperty
  a_sp2_cyc: assert property (p_sp2_cyc) else $error("stack bit test timing");
  property p_sle;
    @(posedge mclk) disable iff (rst)
    (retire && !prefixed && op == OP_BR_SIGNED_LE)
      |-> ev.taken == (flags[FLG_Z] || flags[FLG_N] != flags[FLG_V]);
  endproperty
  a_sle: assert property (p_sle) else $error("signed le condition wrong");
  property p_ult;
    @(posedge mclk) disable iff (rst)
    (retire && !prefixed && op == OP_BR_UNSIGNED_LT) |=> pc == ($past(flags[FLG_C]) ? $past(br_target) : $past(pc_plus2));
  endproperty
  a_ult: assert property (p_ult) else $error("unsigned lower branch wrong");
  property p_ule;
    @(posedge mclk) disable iff (rst)
    (retire && !prefixed && op == OP_BR_UNSIGNED_LE) |-> ev.taken == (flags[FLG_C] | flags[FLG_Z]);
  endproperty
  a_ule: assert property (p_ule) else $error("unsigned le condition wrong");
  property p_slt;
    @(posedge mclk) disable iff (rst)
    (retire && !prefixed && op == OP_BR_SIGNED_LT) |-> ev.taken == (flags[FLG_N] ^ flags[FLG_V]);
  endproperty
  a_slt: assert property (p_slt) else $error("signed lt condition wrong");
  property p_unmasked;
    @(posedge mclk) disable iff (rst)
    (retire && !prefixed && op == OP_BR_IRQ_UNMASKED) |-> ev.taken == !flags[FLG_I];
  endproperty
  a_unmasked: assert property (p_unmasked) else $error("unmasked branch wrong");
  property p_untaken;
    @(posedge mclk) disable iff (rst)
    (retire && ev.is_branch && !ev.taken) |-> cyc == 3'h2 ##1 pc == $past(pc_plus2);
  endproperty
  a_untaken: assert property (p_untaken) else $error("untaken branch wrong");

endmodule

// *** bct_eval.sv ***
// Branch condition evaluator and bit-test flag generator.
// Assumes the core samples taken and flags_bit only on the retire cycle, and is_branch from the cycle after the opcode.
`timescale 1ns/1ps
module bct_eval
  import bct_pkg::*;
(
  // Core side
  bct_eval_if.eval e
);

  // ==========================================================
  // Branch conditions
  always_comb
  begin
    e.is_branch = !e.prefixed;
    e.taken = 1'b0;
    case (e.opcode)
      OP_BR_PIN_HI: e.taken = e.pin;
      OP_BR_PIN_LO: e.taken = !e.pin;
      OP_BR_SIGNED_LE: e.taken = e.flags[FLG_Z] | (e.flags[FLG_N] ^ e.flags[FLG_V]);
      OP_BR_UNSIGNED_LT: e.taken = e.flags[FLG_C];
      OP_BR_UNSIGNED_LE: e.taken = e.flags[FLG_C] | e.flags[FLG_Z];
      OP_BR_SIGNED_LT: e.taken = e.flags[FLG_N] ^ e.flags[FLG_V];
      OP_BR_IRQ_UNMASKED: e.taken = !e.flags[FLG_I];
      default: e.is_branch = 1'b0;
    endcase
  end

  // ==========================================================
  // Bit test: AND feeds flags only, H, I and C kept
  always_comb
  begin
    e.flags_bit = e.flags;
    e.flags_bit[FLG_V] = 1'b0;
    e.flags_bit[FLG_N] = e.acc[7] & e.operand[7];
    e.flags_bit[FLG_Z] = (e.acc & e.operand) == 8'h00;
  end

endmodule

// *** bct_eval_if.sv ***
// Interface between the execution core and its condition evaluator.
// Assumes both ends run in the same clock domain.
`timescale 1ns/1ps
interface bct_eval_if;
  logic [7:0] opcode;
  logic prefixed;
  logic [7:0] flags;
  logic [7:0] acc;
  logic [7:0] operand;
  logic pin;
  logic is_branch;
  logic taken;
  logic [7:0] flags_bit;
  modport core (output opcode, prefixed, flags, acc, operand, pin,
                input is_branch, taken, flags_bit);
  modport eval (input opcode, prefixed, flags, acc, operand, pin,
                output is_branch, taken, flags_bit);
endinterface

// *** bct_mem_model.sv ***
// Byte-wide program/data memory facing the branch and bit-test core.
// Assumes the bench loads the array by hierarchical reference.
`timescale 1ns/1ps
module bct_mem_model
(
  // Clock
  input wire logic mclk,
  // Memory port
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] last = 8'h00;
  // Remember the last byte handed out
  always @(posedge mclk)
  begin
    if (mem_rd)
      last <= mem[mem_addr];
  end
  // Read follows the address at once; an idle port shows the inverse of the last byte
  always_comb
  begin
    mem_rdata = mem_rd ? mem[mem_addr] : ~last;
  end
endmodule

// *** bct_pkg.sv ***
// Constants, state type and opcode decoders for the branch and bit-test core.
// Assumes a byte-wide program/data memory and a 32-bit register bus.
package bct_pkg;

  // ==========================================================
  // Opcodes
  localparam logic [7:0] OP_BR_PIN_HI = 8'h2F;
  localparam logic [7:0] OP_BR_PIN_LO = 8'h2E;
  localparam logic [7:0] OP_BR_SIGNED_LE = 8'h93;
  localparam logic [7:0] OP_BR_UNSIGNED_LT = 8'h25;
  localparam logic [7:0] OP_BR_UNSIGNED_LE = 8'h23;
  localparam logic [7:0] OP_BR_SIGNED_LT = 8'h91;
  localparam logic [7:0] OP_BR_IRQ_UNMASKED = 8'h2C;
  localparam logic [7:0] OP_BIT_IMM = 8'hA5;
  localparam logic [7:0] OP_BIT_DIR = 8'hB5;
  localparam logic [7:0] OP_BIT_EXT = 8'hC5;
  localparam logic [7:0] OP_BIT_IX2 = 8'hD5;
  localparam logic [7:0] OP_BIT_IX1 = 8'hE5;
  localparam logic [7:0] OP_BIT_IX = 8'hF5;
  localparam logic [7:0] OP_PREFIX_SP = 8'h9E;

  // ==========================================================
  // Execution times in clock cycles and the branch target base
  localparam logic [2:0] CYC_BRANCH = 3'h3;
  localparam logic [2:0] CYC_BIT_IMM = 3'h2;
  localparam logic [2:0] CYC_BIT_DIR = 3'h3;
  localparam logic [2:0] CYC_BIT_EXT = 3'h4;
  localparam logic [2:0] CYC_BIT_IX2 = 3'h4;
  localparam logic [2:0] CYC_BIT_IX1 = 3'h3;
  localparam logic [2:0] CYC_BIT_IX = 3'h2;
  localparam logic [2:0] CYC_BIT_SP2 = 3'h5;
  localparam logic [2:0] CYC_BIT_SP1 = 3'h4;
  localparam logic [15:0] BRANCH_BASE = 16'h0002;

  // ==========================================================
  // Flag register layout and reset values
  localparam int FLG_V = 7;
  localparam int FLG_H = 4;
  localparam int FLG_I = 3;
  localparam int FLG_N = 2;
  localparam int FLG_Z = 1;
  localparam int FLG_C = 0;
  localparam logic [7:0] FLAGS_FIXED = 8'h60;
  localparam logic [7:0] FLAGS_RST = 8'h68;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [15:0] SP_RST = 16'h00FF;

  // ==========================================================
  // Register map (byte addresses) and bit positions
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_PC = 8'h08;
  localparam logic [7:0] REG_ACC = 8'h0C;
  localparam logic [7:0] REG_INDEX = 8'h10;
  localparam logic [7:0] REG_SP = 8'h14;
  localparam logic [7:0] REG_FLAGS = 8'h18;
  localparam logic [7:0] REG_LAST_CYC = 8'h1C;
  localparam int CTRL_STEP = 0;
  localparam int CTRL_RUN = 1;
  localparam int ST_BUSY = 0;
  localparam int ST_BADOP = 1;

  typedef enum logic [1:0] {BCT_IDLE = 2'h0, BCT_EXEC = 2'h1, BCT_DONE = 2'h3} bct_state_t;

  // Cycle count of an opcode, zero when unsupported
  function automatic logic [2:0] bct_op_cycles(input logic [7:0] op, input logic pfx);
    logic [2:0] c;
    c = 3'h0;
    if (pfx)
    begin
      if (op == OP_BIT_IX2) c = CYC_BIT_SP2;
      else if (op == OP_BIT_IX1) c = CYC_BIT_SP1;
    end
    else
    begin
      case (op)
        OP_BR_PIN_HI, OP_BR_PIN_LO, OP_BR_SIGNED_LE, OP_BR_UNSIGNED_LT,
        OP_BR_UNSIGNED_LE, OP_BR_SIGNED_LT, OP_BR_IRQ_UNMASKED: c = CYC_BRANCH;
        OP_BIT_IMM: c = CYC_BIT_IMM;
        OP_BIT_DIR: c = CYC_BIT_DIR;
        OP_BIT_EXT: c = CYC_BIT_EXT;
        OP_BIT_IX2: c = CYC_BIT_IX2;
        OP_BIT_IX1: c = CYC_BIT_IX1;
        OP_BIT_IX: c = CYC_BIT_IX;
        default: c = 3'h0;
      endcase
    end
    return c;
  endfunction

  // Instruction length in bytes, prefix included
  function automatic logic [15:0] bct_op_len(input logic [7:0] op, input logic pfx);
    logic [15:0] n;
    n = 16'h0002;
    if (op == OP_BIT_EXT || op == OP_BIT_IX2) n = 16'h0003;
    else if (op == OP_BIT_IX) n = 16'h0001;
    if (pfx) n = n + 16'h0001;
    return n;
  endfunction

endpackage

// *** branch_condition_and_bit_test_tb_top.sv ***
// Self-checking bench for the branch and bit-test core.
// Assumes the core header of bct_core and the memory model beside it.
`timescale 1ns/1ps
module branch_condition_and_bit_test_tb_top
  import bct_pkg::*;
;
  // ==========================================================
  // Signals
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [15:0] mem_addr;
  logic mem_rd;
  logic [7:0] mem_rdata;
  logic ext_int_pin = 1'b0;
  logic instr_done;
  int failures = 0;
  int num_checks = 0;
  logic [31:0] seed = 32'hCC47;
  logic [15:0] ops [0:14] = '{16'h002F, 16'h002E, 16'h0093, 16'h0025, 16'h0023,
    16'h0091, 16'h002C, 16'h00A5, 16'h00B5, 16'h00C5, 16'h00D5, 16'h00E5, 16'h00F5,
    16'h9ED5, 16'h9EE5};

  // Clock at 100 MHz
  always #5 mclk = ~mclk;

  // ==========================================================
  // Design and partner
  bct_core u_bct_core (.mclk(mclk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata),
    .ext_int_pin(ext_int_pin), .instr_done(instr_done));
  bct_mem_model u_bct_mem_model (.mclk(mclk), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_rdata(mem_rdata));

  // ==========================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, seen, exp);
    end
  endtask

  task automatic test_done();
    if (failures == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Avalon access: hold until waitrequest is seen low, then release and let an edge pass
  task automatic av(input logic wr, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do
      @(posedge mclk);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge mclk);
  endtask

  // Step one instruction and wait for its retire pulse, then three more cycles
  task automatic step();
    logic [31:0] q;
    int n;
    av(1'b1, REG_CTRL, 32'h1, q);
    n = 0;
    while (instr_done !== 1'b1 && n < 40)
    begin
      @(posedge mclk);
      n++;
    end
    chk({31'h0, instr_done}, 32'h1, "retire pulse");
    repeat (3) @(posedge mclk);
  endtask

  // Watchdog
  initial
  begin
    repeat (20000) @(posedge mclk);
    failures++;
    test_done();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    logic [31:0] q;
    logic [15:0] op, p, ix, sp, ea, pc_exp;
    logic [7:0] f, acc, b1, b2, res, f_exp, mv;
    logic tk;
    int cy, len;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    av(1'b0, REG_PC, 32'h0, q);
    chk(q, 32'h0, "pc reset");
    av(1'b0, REG_SP, 32'h0, q);
    chk(q, 32'hFF, "sp reset");
    av(1'b0, REG_FLAGS, 32'h0, q);
    chk(q, 32'h68, "flags reset");
    av(1'b0, 8'h20, 32'h0, q);
    chk(q, 32'h0, "unmapped read");
    for (int k = 0; k < 75; k++)
    begin
      op = ops[k % 15];
      seed = lfsr(seed);
      {p, ix} = seed;
      seed = lfsr(seed);
      {sp, f, acc} = seed;
      seed = lfsr(seed);
      {b1, b2} = seed[15:0];
      f = f | FLAGS_FIXED;
      ext_int_pin <= seed[16];
      // Operand address of each bit-test form
      case (op)
        16'h00A5: ea = p + 16'h1;
        16'h00B5: ea = {8'h00, b1};
        16'h00C5: ea = {b1, b2};
        16'h00D5: ea = ix + {b1, b2};
        16'h00E5: ea = ix + {8'h00, b1};
        16'h9ED5: ea = sp + {b1, b2};
        16'h9EE5: ea = sp + {8'h00, b1};
        default: ea = ix;
      endcase
      u_bct_mem_model.mem[ea] = seed[31:24];
      if (op[15:8] == OP_PREFIX_SP)
        {u_bct_mem_model.mem[p], u_bct_mem_model.mem[p + 16'h1],
         u_bct_mem_model.mem[p + 16'h2], u_bct_mem_model.mem[p + 16'h3]} = {op, b1, b2};
      else
        {u_bct_mem_model.mem[p], u_bct_mem_model.mem[p + 16'h1],
         u_bct_mem_model.mem[p + 16'h2]} = {op[7:0], b1, b2};
      res = acc & u_bct_mem_model.mem[ea];
      mv = u_bct_mem_model.mem[ea];
      // Expected cycles, length and branch decision
      case (op)
        16'h00A5, 16'h00F5: cy = 2;
        16'h00B5, 16'h00E5: cy = 3;
        16'h00C5, 16'h00D5, 16'h9EE5: cy = 4;
        16'h9ED5: cy = 5;
        default: cy = 3;
      endcase
      case (op)
        16'h00F5: len = 1;
        16'h00C5, 16'h00D5, 16'h9EE5: len = 3;
        16'h9ED5: len = 4;
        default: len = 2;
      endcase
      case (op)
        16'h002F: tk = seed[16];
        16'h002E: tk = ~seed[16];
        16'h0093: tk = f[FLG_Z] | (f[FLG_N] ^ f[FLG_V]);
        16'h0025: tk = f[FLG_C];
        16'h0023: tk = f[FLG_C] | f[FLG_Z];
        16'h0091: tk = f[FLG_N] ^ f[FLG_V];
        16'h002C: tk = ~f[FLG_I];
        default: tk = 1'b0;
      endcase
      pc_exp = p + 16'(len) + (tk ? {{8{b1[7]}}, b1} : 16'h0);
      f_exp = (op[7:0] == 8'hA5 || op[7:4] > 4'hA) ? {1'b0, f[6:3], res[7], res == 8'h0, f[0]} : f;
      av(1'b1, REG_PC, {16'h0, p}, q);
      av(1'b1, REG_ACC, {24'h0, acc}, q);
      av(1'b1, REG_INDEX, {16'h0, ix}, q);
      av(1'b1, REG_SP, {16'h0, sp}, q);
      av(1'b1, REG_FLAGS, {24'h0, f}, q);
      step();
      av(1'b0, REG_PC, 32'h0, q);
      chk(q, {16'h0, pc_exp}, "pc");
      chk(q, {16'h0, pc_exp}, "pc");
      av(1'b0, REG_FLAGS, 32'h0, q);
      chk(q, {24'h0, f_exp}, "flags");
      av(1'b0, REG_ACC, 32'h0, q);
      chk(q, {24'h0, acc}, "acc kept");
      chk({24'h0, u_bct_mem_model.mem[ea]}, {24'h0, mv}, "mem");
      av(1'b0, REG_LAST_CYC, 32'h0, q);
      chk(q, 32'(cy), "cycles");
    end
    // Prefix followed by a branch opcode is refused and leaves the PC alone
    {u_bct_mem_model.mem[16'h0040], u_bct_mem_model.mem[16'h0041]} = 16'h9E93;
    av(1'b1, REG_PC, 32'h40, q);
    step();
    av(1'b0, REG_STATUS, 32'h0, q);
    chk(q & 32'h2, 32'h2, "bad opcode flag");
    av(1'b0, REG_PC, 32'h0, q);
    chk(q, 32'h40, "pc after bad opcode");
    av(1'b1, REG_STATUS, 32'h2, q);
    av(1'b0, REG_STATUS, 32'h0, q);
    chk(q, 32'h0, "status cleared");
    // Run mode: a bit test, then the refused pair stops the run
    {u_bct_mem_model.mem[16'h003E], u_bct_mem_model.mem[16'h003F]} = 16'hA580;
    av(1'b1, REG_PC, 32'h3E, q);
    av(1'b1, REG_CTRL, 32'h2, q);
    repeat (20) @(posedge mclk);
    av(1'b0, REG_CTRL, 32'h0, q);
    chk(q, 32'h0, "run cleared by fault");
    av(1'b0, REG_STATUS, 32'h0, q);
    chk(q & 32'h2, 32'h2, "fault in run mode");
    av(1'b0, REG_PC, 32'h0, q);
    chk(q, 32'h40, "pc after run");
    test_done();
  end
endmodule
